// File: design/sbft_pkg.sv
package sbft_pkg;
  // Array sizes of the two variants
  localparam int NARROW_WORDS  = 2097152;
  localparam int WIDE_WORDS    = 1048576;
  localparam int NARROW_ADDR_W = 21;
  localparam int WIDE_ADDR_W   = 20;
  localparam int NARROW_LANES  = 2;
  localparam int WIDE_LANES    = 4;
  // Byte lane: 8 data bits plus parity
  localparam int LANE_W        = 9;
  localparam int LANE_DATA_W   = 8;
  localparam int PARITY_POS    = 8;
  // Burst counter
  localparam int BURST_W       = 2;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] CNT_RST    = 2'h0;
  // Write buffer
  localparam int FIFO_DEPTH    = 16;

  typedef enum logic [1:0] {
    SBFT_DESEL,
    SBFT_READ,
    SBFT_WRITE
  } sbft_op_t;
endpackage

// File: design/sbft_sram.sv
`timescale 1ns/10ps

module sbft_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  // Depth must be a power of two
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } sbft_fifo_state_t;

  sbft_fifo_state_t s_r;
  sbft_fifo_state_t s_nxt;
  logic [W-1:0]     mem [0:DEPTH-1];
  logic             push;
  logic             pop;

  assign in_ready  = (s_r.cnt != CW'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[s_r.wp] <= in_data;
    end
  end
endmodule

// What this block does
// - All synchronous pins are sampled only on the rising clock edge.
// - Narrow variant 2M words of 18 bits; wide variant 1M of 36.
// - Reads and writes follow each other back to back, no idle cycle.
// - A 2-bit burst counter makes the low two address bits.
// - Both interleaved and linear burst orders are offered.
// - Sleep request high puts the memory into power-down sleep.
// - Array contents and internal state are kept while asleep.
// - Sleep request low again resumes normal synchronous operation.
// - Array writes are timed internally from the registered command.
// - Inputs registered; flow-through read data on a shared three-state bus.
// - Output enable acts asynchronously; deasserted means bus not driven.
// - Per-lane write enables, four wide, two narrow; only enabled lanes written.
// - Three chip selects must all be asserted to select the memory.
// - Load/advance picks new external address or burst advance.
// - Clock gate high makes an edge be ignored.
// - Narrow lanes carry 8 data plus 1 parity bit, handled alike.
// - Select high inverts low bits interleaved; low counts up modulo four.
// - New access needs selects and load low; write strobe picks direction.
// - Ignored edge keeps command state and takes no write data, but a buffered write still drains; bus keeps its drive state.
// - Write with all lane enables high writes nothing, address still moves.
module sbft_sram #(
  parameter bit  WIDE  = 1'b0,
  localparam int AW    = WIDE ? sbft_pkg::WIDE_ADDR_W : sbft_pkg::NARROW_ADDR_W,
  localparam int LANES = WIDE ? sbft_pkg::WIDE_LANES : sbft_pkg::NARROW_LANES,
  localparam int DL    = LANES * sbft_pkg::LANE_DATA_W
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [AW-1:0]       addr_inputs,
  input  wire logic                chip_select_a_n,
  input  wire logic                chip_select_b_high,
  input  wire logic                chip_select_c_n,
  input  wire logic                load_advance,
  input  wire logic                write_n,
  input  wire logic [LANES-1:0]    byte_lane_write_n,
  input  wire logic                clock_gate_n,
  input  wire logic                output_enable_n,
  input  wire logic                burst_order_sel,
  input  wire logic                sleep_request,
  input  wire logic [DL-1:0]       data_lines_in,
  output logic      [DL-1:0]       data_lines_out,
  output logic                     data_lines_oe,
  input  wire logic [LANES-1:0]    parity_lines_in,
  output logic      [LANES-1:0]    parity_lines_out,
  output logic                     parity_lines_oe,
  output logic                     write_buffer_ready,
  output logic                     sleep_active
);
  localparam int WORDS = WIDE ? sbft_pkg::WIDE_WORDS : sbft_pkg::NARROW_WORDS;
  localparam int DW    = LANES * sbft_pkg::LANE_W;
  localparam int FW    = AW + LANES + DW;

  typedef struct packed {
    logic              sleep_m;
    logic              sleep_s;
    logic              mode_m;
    logic              mode_s;
    sbft_pkg::sbft_op_t op;
    logic [AW-1:0]     addr;
    logic [1:0]        base_lo;
    logic [1:0]        cnt;
    logic [LANES-1:0]  wen;
  } sbft_state_t;

  sbft_state_t      s_r;
  sbft_state_t      s_nxt;
  logic [DW-1:0]    mem [0:WORDS-1];
  logic             selected;
  logic             push_need;
  logic             fifo_in_ready;
  logic             act;
  logic [1:0]       step;
  logic [DW-1:0]    wr_lanes;
  logic [FW-1:0]    head;
  logic             head_valid;
  logic [AW-1:0]    head_addr;
  logic [LANES-1:0] head_mask;
  logic [DW-1:0]    head_data;
  logic             drain;
  logic             hit;
  logic [DW-1:0]    mem_rd;
  logic [DW-1:0]    fwd;
  logic [DW-1:0]    merged;
  logic             drive;

  assign selected  = !chip_select_a_n && chip_select_b_high && !chip_select_c_n;
  assign push_need = (s_r.op == sbft_pkg::SBFT_WRITE) && (|s_r.wen);
  // Edge acted on only when gated in, awake and, if a write is pending, buffer has room
  assign act = !clock_gate_n && !s_r.sleep_s && (!push_need || fifo_in_ready);
  assign step = s_r.cnt + sbft_pkg::BURST_STEP;
  assign write_buffer_ready = fifo_in_ready;
  assign sleep_active = s_r.sleep_s;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sleep_m = sleep_request;
    s_nxt.sleep_s = s_r.sleep_m;
    s_nxt.mode_m  = burst_order_sel;
    s_nxt.mode_s  = s_r.mode_m;
    if (act) begin
      s_nxt.wen = ~byte_lane_write_n;
      if (!load_advance) begin
        if (selected) begin
          s_nxt.op      = write_n ? sbft_pkg::SBFT_READ : sbft_pkg::SBFT_WRITE;
          s_nxt.addr    = addr_inputs;
          s_nxt.base_lo = addr_inputs[1:0];
          s_nxt.cnt     = sbft_pkg::CNT_RST;
        end else begin
          s_nxt.op = sbft_pkg::SBFT_DESEL;
        end
      end else if (s_r.op != sbft_pkg::SBFT_DESEL) begin
        s_nxt.cnt = step;
        if (s_r.mode_s) begin
          s_nxt.addr[1:0] = s_r.base_lo ^ step;
        end else begin
          s_nxt.addr[1:0] = s_r.base_lo + step;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r         <= '0;
      s_r.op      <= sbft_pkg::SBFT_DESEL;
      s_r.cnt     <= sbft_pkg::CNT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Write data taken one acted edge after its command, then buffered
  sbft_fifo #(
    .W     (FW),
    .DEPTH (sbft_pkg::FIFO_DEPTH)
  ) u_wbuf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (act && push_need),
    .in_ready  (fifo_in_ready),
    .in_data   ({s_r.addr, s_r.wen, wr_lanes}),
    .out_valid (head_valid),
    .out_ready (drain),
    .out_data  (head)
  );

  assign {head_addr, head_mask, head_data} = head;
  assign drain  = !s_r.sleep_s;
  assign hit    = head_valid && (head_addr == s_r.addr);
  assign mem_rd = mem[s_r.addr];

  for (genvar k = 0; k < LANES; k++) begin : g_lane
    localparam int B = k * sbft_pkg::LANE_W;
    localparam int D = k * sbft_pkg::LANE_DATA_W;
    assign wr_lanes[B +: sbft_pkg::LANE_W] =
      {parity_lines_in[k], data_lines_in[D +: sbft_pkg::LANE_DATA_W]};
    assign merged[B +: sbft_pkg::LANE_W] = head_mask[k] ?
      head_data[B +: sbft_pkg::LANE_W] : mem[head_addr][B +: sbft_pkg::LANE_W];
    assign fwd[B +: sbft_pkg::LANE_W] = (hit && head_mask[k]) ?
      head_data[B +: sbft_pkg::LANE_W] : mem_rd[B +: sbft_pkg::LANE_W];
    assign data_lines_out[D +: sbft_pkg::LANE_DATA_W] =
      fwd[B +: sbft_pkg::LANE_DATA_W];
    assign parity_lines_out[k] = fwd[B + sbft_pkg::PARITY_POS];
  end

  always_ff @(posedge clock) begin
    if (head_valid && drain) begin
      mem[head_addr] <= merged;
    end
  end

  // Output enable pin gates the drivers without a clock
  assign drive = (s_r.op == sbft_pkg::SBFT_READ) && !output_enable_n && !s_r.sleep_s;
  assign data_lines_oe   = drive;
  assign parity_lines_oe = drive;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence new_rd_s;
    act && !load_advance && selected && write_n;
  endsequence

  sequence new_wr_s;
    act && !load_advance && selected && !write_n;
  endsequence

  stall_hold_a: assert property (
    clock_gate_n |=> $stable(s_r.addr) && $stable(s_r.op) && $stable(s_r.cnt))
    else $error("state moved on a gated edge");

  sleep_hold_a: assert property (
    s_r.sleep_s |=> $stable(s_r.addr) && $stable(s_r.op) && $stable(s_r.cnt)
    && $stable(head_valid))
    else $error("state moved while asleep");

  load_addr_a: assert property (
    new_rd_s or new_wr_s |=> s_r.addr == $past(addr_inputs) && s_r.cnt == 2'h0)
    else $error("external address not loaded");

  linear_step_a: assert property (
    act && load_advance && s_r.op != sbft_pkg::SBFT_DESEL && !s_r.mode_s
    |=> s_r.addr[1:0] == $past(s_r.addr[1:0]) + 2'h1)
    else $error("linear burst did not count up");

  interleave_step_a: assert property (
    act && load_advance && s_r.op != sbft_pkg::SBFT_DESEL && s_r.mode_s
    |=> s_r.cnt == $past(s_r.cnt) + 2'h1 && s_r.addr[AW-1:2] == $past(s_r.addr[AW-1:2])
    && (s_r.addr[1:0] ^ s_r.base_lo) == s_r.cnt)
    else $error("interleaved burst order wrong");

  deselect_a: assert property (
    act && !load_advance && !selected |=> s_r.op == sbft_pkg::SBFT_DESEL && !data_lines_oe)
    else $error("deselect not taken");

  turnaround_a: assert property (
    new_rd_s ##1 new_wr_s |=> s_r.op == sbft_pkg::SBFT_WRITE && !data_lines_oe)
    else $error("write did not follow read at once");

  oe_gate_a: assert property (
    output_enable_n || s_r.op != sbft_pkg::SBFT_READ |-> !data_lines_oe && !parity_lines_oe)
    else $error("bus driven with enable off");

  read_drive_a: assert property (
    new_rd_s ##1 (!output_enable_n && !s_r.sleep_s) |-> data_lines_oe)
    else $error("flow-through read not driven");

  abort_a: assert property (
    new_wr_s ##0 (&byte_lane_write_n)
    |=> s_r.op == sbft_pkg::SBFT_WRITE && !push_need && !data_lines_oe)
    else $error("aborted write reached the buffer");

  sleep_entry_a: assert property (
    sleep_request ##1 sleep_request |=> s_r.sleep_s)
    else $error("sleep not entered after request");

  sleep_exit_a: assert property (
    !sleep_request ##1 !sleep_request |=> !s_r.sleep_s)
    else $error("sleep not left after release");
endmodule

// File: bench/sbft_host.sv
`timescale 1ns/10ps
module sbft_host (
  input  wire logic   clock,
  output logic [20:0] addr,
  output logic [2:0]  sels,
  output logic        ld,
  output logic        wr_n,
  output logic [1:0]  lane_n,
  output logic [15:0] din,
  output logic [1:0]  pin
);
  logic [2:0]  sel_cfg = 3'h2;
  logic        wr_b    = 1'b0;
  logic [17:0] pend    = 18'h0_0000;
  initial begin
    {addr, sels, ld, wr_n} = {21'h0, 3'h3, 2'h1};
    {lane_n, din, pin} = {2'h3, 18'h0_0000};
  end
  // One command a cycle; write data one edge after its command
  task automatic cmd(input logic l, w, input logic [20:0] a,
                     input logic [1:0] ln, input logic [17:0] d);
    @(negedge clock);
    if (wr_b) begin
      {pin[1], din[15:8], pin[0], din[7:0]} = pend;
    end else begin
      {pin, din} = ~{pin, din};
    end
    {ld, wr_n, addr, lane_n, sels} = {l, w, a, ln, sel_cfg};
    if (!l) begin
      wr_b = !w && sel_cfg == 3'h2;
    end
    pend = d;
    @(posedge clock);
    #1;
  endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clock, rst, gate_n, oe_n, order, sleep;
  logic        ld, wr_n, doe, poe, wbr, slp;
  logic [20:0] addr;
  logic [2:0]  sels;
  logic [1:0]  lane_n, pin, pout;
  logic [15:0] din, dout;
  logic [17:0] q;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  assign q = {pout[1], dout[15:8], pout[0], dout[7:0]};
  sbft_host h (.clock(clock), .addr(addr), .sels(sels), .ld(ld), .wr_n(wr_n),
               .lane_n(lane_n), .din(din), .pin(pin));
  sbft_sram #(.WIDE(1'b0)) u_dut (
    .clock(clock), .rst(rst), .addr_inputs(addr), .chip_select_a_n(sels[2]),
    .chip_select_b_high(sels[1]), .chip_select_c_n(sels[0]), .load_advance(ld),
    .write_n(wr_n), .byte_lane_write_n(lane_n), .clock_gate_n(gate_n),
    .output_enable_n(oe_n), .burst_order_sel(order), .sleep_request(sleep),
    .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(doe),
    .parity_lines_in(pin), .parity_lines_out(pout), .parity_lines_oe(poe),
    .write_buffer_ready(wbr), .sleep_active(slp));
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [17:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [20:0] a, input logic [17:0] e);
    h.cmd(1'b0, 1'b1, a, h.lane_n, 18'h0_0000);
    chk("read data", e, q);
  endtask
  task automatic wr(input logic [20:0] a, input logic [1:0] ln, input logic [17:0] d);
    h.cmd(1'b0, 1'b0, a, ln, d);
  endtask
  task automatic nop;
    h.cmd(1'b0, 1'b1, 21'h0, 2'h0, 18'h0_0000);
  endtask
  task automatic t_rw;
    wr(21'h1_2340, 2'h0, 18'h1_5a3c);
    rd(21'h1_2340, 18'h1_5a3c);
    chk("drive", 18'h3, {16'h0, doe, poe});
    wr(21'h0_0007, 2'h0, 18'h2_c3a5);
    rd(21'h0_0007, 18'h2_c3a5);
    rd(21'h1_2340, 18'h1_5a3c);
    $display("test rw done");
  endtask
  task automatic t_burst;
    for (int i = 0; i < 4; i++) begin
      h.cmd(i != 0, 1'b0, 21'h0_0101, 2'h0, 18'h2_a5a0 + 18'(i));
    end
    nop;
    @(negedge clock) order = 1'b1;
    repeat (3) nop;
    rd(21'h0_0101, 18'h2_a5a0);
    for (int i = 1; i < 4; i++) begin
      h.cmd(1'b1, 1'b1, 21'h0, 2'h0, 18'h0_0000);
      chk("burst data", 18'h2_a5a0 + 18'(4 - i), q);
    end
    $display("test burst done");
  endtask
  task automatic t_lanes;
    wr(21'h0_0033, 2'h0, 18'h3_ffff);
    wr(21'h0_0033, 2'h2, 18'h0_0000);
    wr(21'h0_0033, 2'h3, 18'h0_0000);
    chk("abort drive", 18'h0, {17'h0, doe});
    rd(21'h0_0033, 18'h3_fe00);
    $display("test lanes done");
  endtask
  task automatic t_gate;
    rd(21'h1_2340, 18'h1_5a3c);
    @(negedge clock) gate_n = 1'b1;
    h.cmd(1'b0, 1'b1, 21'h0_0007, 2'h0, 18'h0_0000);
    chk("gated data", 18'h1_5a3c, q);
    chk("gated drive", 18'h1, {17'h0, doe});
    @(negedge clock) gate_n = 1'b0;
    $display("test gate done");
  endtask
  task automatic t_oe;
    @(negedge clock) oe_n = 1'b1;
    h.cmd(1'b0, 1'b1, 21'h0_0007, 2'h0, 18'h0_0000);
    chk("oe off", 18'h0, {16'h0, doe, poe});
    @(negedge clock) oe_n = 1'b0;
    #1;
    chk("oe on", 18'h3, {16'h0, doe, poe});
    chk("oe data", 18'h2_c3a5, q);
    $display("test oe done");
  endtask
  task automatic t_sel;
    for (int i = 0; i < 3; i++) begin
      h.sel_cfg = 3'h2 ^ (3'h1 << i);
      h.cmd(1'b0, 1'b1, 21'h0_0007, 2'h0, 18'h0_0000);
      chk("deselect", 18'h0, {17'h0, doe});
    end
    h.sel_cfg = 3'h2;
    $display("test select done");
  endtask
  task automatic t_sleep;
    rd(21'h0_0007, 18'h2_c3a5);
    @(negedge clock) sleep = 1'b1;
    repeat (4) @(negedge clock);
    chk("asleep", 18'h1, {17'h0, slp});
    wr(21'h1_2340, 2'h0, 18'h0_0000);
    nop;
    chk("asleep drive", 18'h0, {17'h0, doe});
    @(negedge clock) sleep = 1'b0;
    repeat (4) @(negedge clock);
    rd(21'h1_2340, 18'h1_5a3c);
    $display("test sleep done");
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      conclude;
    end
  end
  initial begin
    {rst, gate_n, oe_n, order, sleep} = 5'h10;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    chk("ready", 18'h1, {17'h0, wbr});
    t_rw;
    t_burst;
    t_lanes;
    t_gate;
    t_oe;
    t_sel;
    t_sleep;
    conclude;
  end
endmodule
